// >>> design/dcip_pkg.sv
package dcip_pkg;

	// clock period in picoseconds (250 MHz)
	localparam int CLK_PERIOD_PS   = 4000;
	// park filter rejects edges up to this length
	localparam int PARK_FILT_NS    = 150;
	localparam int PARK_FILT_CYC   = (PARK_FILT_NS * 1000 + CLK_PERIOD_PS - 1)
	                                 / CLK_PERIOD_PS + 1;
	// park warning lead time
	localparam int PARK_WARN_US    = 32;
	localparam int PARK_WARN_CYC   = (PARK_WARN_US * 1000000) / CLK_PERIOD_PS;
	// mirror park sequence length (must fit inside the warning interval)
	localparam int PARK_SEQ_CYC    = PARK_WARN_CYC / 2;
	localparam int FILT_CW         = 6;
	localparam int PARK_CW         = 13;
	localparam logic [FILT_CW-1:0] FILT_LAST =
		FILT_CW'(PARK_FILT_CYC - 1);
	localparam logic [PARK_CW-1:0] PARK_LAST =
		PARK_CW'(PARK_SEQ_CYC - 1);
	localparam logic [PARK_CW-1:0] PARK_ZERO = '0;

	typedef enum {
		ST_RESET,
		ST_PLL_WAIT,
		ST_CFG_LOAD,
		ST_READY,
		ST_PARKING,
		ST_PARKED
	} dcip_state_t;

	// pins that go high-impedance during reset
	typedef struct packed {
		logic illum_color_pick_0;
		logic illum_color_pick_1;
		logic flash_serial_clock;
		logic flash_serial_out;
		logic flash_chip_select_low;
	} dcip_tri_t;

	// status toward the rest of the controller
	typedef struct packed {
		logic init_busy;
		logic init_done;
		logic parking;
		logic parked;
		logic power_down;
	} dcip_stat_t;

endpackage : dcip_pkg

// >>> design/dcip_park_filter.sv
`timescale 1ns/10ps
`default_nettype none

module dcip_park_filter
	import dcip_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// synchronised raw level and filtered level
	input  wire logic raw_in,
	output logic      filt_out
);

	logic [FILT_CW-1:0] cnt_r;

	// RQ13 glitch filter window
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_r    <= '0;
			filt_out <= 1'b1;
		end else if (raw_in == filt_out) begin
			cnt_r <= '0;
		end else if (cnt_r == FILT_LAST) begin
			cnt_r    <= '0;
			filt_out <= raw_in;
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

endmodule : dcip_park_filter

`default_nettype wire

// >>> design/dcip_init_park_seq.sv
// Operation
// RQ1: monitor holds reset low until supplies good
// RQ2: reset drives outputs inactive, bidirs input
// RQ3: reset tri-states illumination and flash pins
// RQ4: monitor releases reset after stable clock
// RQ5: after reset, PLL lock then config load
// RQ6: reset release makes all pins active
// RQ7: drive host interrupt high during init
// RQ8: drive host interrupt low when init done
// RQ9: host waits for interrupt low before I2C
// RQ10: park warning comes 32 us early
// RQ11: park mirrors within the warning interval
// RQ12: clock and reset held 32 us after park
// RQ13: filter park input glitches up to 150ns
// RQ14: power request pin starts or parks device
// RQ15: synchronise reset release and park input
// RQ16: keep interrupt low after init completes
`timescale 1ns/10ps
`default_nettype none

module dcip_init_park_seq
	import dcip_pkg::*;
(
	// clock and synchronous reset
	input  wire logic  clk,
	input  wire logic  rst,
	// external pins
	input  wire logic  sys_reset_low,
	input  wire logic  mirror_park_request_low,
	input  wire logic  projector_power_request,
	// core handshakes
	input  wire logic  pll_locked,
	input  wire logic  cfg_load_done,
	output logic       cfg_load_start,
	output logic       mirror_park_cmd,
	input  wire logic  mirror_park_ack,
	// pin control: output enables, low = driven
	output logic       host_irq_out,
	output logic       host_irq_oe_low,
	output dcip_tri_t  tri_oe_low,
	output logic       bidir_oe_low,
	output logic       outputs_inactive,
	// status
	output dcip_stat_t status
);

	////////////////////////////////////////////////////////////////////////
	// synchronisers

	logic [1:0] rstz_sync_r;
	logic [1:0] park_sync_r;
	logic [1:0] pon_sync_r;
	logic [1:0] lock_sync_r;
	logic       park_filt;
	logic       in_reset;

	// RQ15 two-flop synchronisers
	always_ff @(posedge clk) begin
		if (rst) begin
			rstz_sync_r <= '0;
			park_sync_r <= 2'h3;
			pon_sync_r  <= '0;
			lock_sync_r <= '0;
		end else begin
			rstz_sync_r <= {rstz_sync_r[0], sys_reset_low};
			park_sync_r <= {park_sync_r[0], mirror_park_request_low};
			pon_sync_r  <= {pon_sync_r[0], projector_power_request};
			lock_sync_r <= {lock_sync_r[0], pll_locked};
		end
	end

	assign in_reset = rst | ~rstz_sync_r[1];

	dcip_park_filter u_filt (
		.clk      (clk),
		.rst      (in_reset),
		.raw_in   (park_sync_r[1]),
		.filt_out (park_filt)
	);

	////////////////////////////////////////////////////////////////////////
	// sequencer

	dcip_state_t        state_r;
	dcip_state_t        state_nxt;
	logic [PARK_CW-1:0] park_cnt_r;
	logic               park_fast_r;
	logic               park_enter;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_RESET: begin
				// RQ14 wait for power request
				if (pon_sync_r[1] && park_filt)
					state_nxt = ST_PLL_WAIT;
			end
			ST_PLL_WAIT: begin
				// RQ5 lock before config load
				if (lock_sync_r[1])
					state_nxt = ST_CFG_LOAD;
			end
			ST_CFG_LOAD: begin
				if (cfg_load_done)
					state_nxt = ST_READY;
			end
			ST_READY: begin
				// RQ11 park warning or power request low
				if (!park_filt || !pon_sync_r[1])
					state_nxt = ST_PARKING;
			end
			ST_PARKING: begin
				if (mirror_park_ack || park_cnt_r == PARK_ZERO)
					state_nxt = ST_PARKED;
			end
			ST_PARKED: begin
				if (pon_sync_r[1] && park_filt && !park_fast_r)
					state_nxt = ST_PLL_WAIT;
			end
			default: state_nxt = ST_RESET;
		endcase
		// RQ11 warning during init parks too
		if ((state_r == ST_PLL_WAIT || state_r == ST_CFG_LOAD) && !park_filt)
			state_nxt = ST_PARKING;
	end

	always_ff @(posedge clk) begin
		if (in_reset)
			state_r <= ST_RESET;
		else
			state_r <= state_nxt;
	end

	assign park_enter = state_r != ST_PARKING &&
	                    state_nxt == ST_PARKING;

	// RQ11 park deadline counter
	always_ff @(posedge clk) begin
		if (in_reset)
			park_cnt_r <= PARK_LAST;
		else if (park_enter)
			park_cnt_r <= PARK_LAST;
		else if (state_r == ST_PARKING && park_cnt_r != PARK_ZERO)
			park_cnt_r <= park_cnt_r - 1'b1;
	end

	// fast park needs a full reset to restart
	always_ff @(posedge clk) begin
		if (in_reset)
			park_fast_r <= 1'b0;
		else if (park_enter)
			park_fast_r <= ~park_filt;
	end

	////////////////////////////////////////////////////////////////////////
	// pin and status outputs

	always_ff @(posedge clk) begin
		if (in_reset) begin
			// RQ2 inactive outputs, bidirs as inputs
			outputs_inactive <= 1'b1;
			bidir_oe_low     <= 1'b1;
		end else begin
			// RQ6 all pins active after release
			outputs_inactive <= 1'b0;
			bidir_oe_low     <= 1'b0;
		end
	end

	// RQ3 tri-state selected pins in reset
	always_ff @(posedge clk) begin
		if (in_reset)
			tri_oe_low <= '1;
		else
			tri_oe_low <= '0;
	end

	// RQ7 pull-up holds the line until driven
	always_ff @(posedge clk) begin
		if (in_reset)
			host_irq_oe_low <= 1'b1;
		else
			host_irq_oe_low <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (in_reset) begin
			host_irq_out <= 1'b1;
		end else begin
			// RQ7 high during init, RQ8 low when done
			// RQ16 stays low until another init
			host_irq_out <= (state_nxt == ST_RESET ||
			                 state_nxt == ST_PLL_WAIT ||
			                 state_nxt == ST_CFG_LOAD);
		end
	end

	// RQ5 load request only after lock
	always_ff @(posedge clk) begin
		if (in_reset)
			cfg_load_start <= 1'b0;
		else
			cfg_load_start <= (state_nxt == ST_CFG_LOAD);
	end

	// RQ11 park command while parking
	always_ff @(posedge clk) begin
		if (in_reset)
			mirror_park_cmd <= 1'b0;
		else
			mirror_park_cmd <= (state_nxt == ST_PARKING);
	end

	always_ff @(posedge clk) begin
		if (in_reset) begin
			status <= '0;
		end else begin
			status.init_busy  <= (state_nxt == ST_PLL_WAIT ||
			                      state_nxt == ST_CFG_LOAD);
			status.init_done  <= (state_nxt == ST_READY);
			status.parking    <= (state_nxt == ST_PARKING);
			status.parked     <= (state_nxt == ST_PARKED);
			// RQ14 power-down after a normal park
			status.power_down <= (state_nxt == ST_PARKED && !pon_sync_r[1]);
		end
	end

endmodule : dcip_init_park_seq

`default_nettype wire

// >>> tb/dcip_chk.sv
`timescale 1ns/10ps
`default_nettype none
module dcip_chk
	import dcip_pkg::*;
(
	// watched ports
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       sys_reset_low,
	input wire logic       pll_locked,
	input wire logic       cfg_load_start,
	input wire logic       mirror_park_cmd,
	input wire logic       host_irq_out,
	input wire logic       host_irq_oe_low,
	input wire dcip_tri_t  tri_oe_low,
	input wire logic       bidir_oe_low,
	input wire logic       outputs_inactive,
	input wire dcip_stat_t status
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	int park_run;
	// consecutive cycles with the park command up
	always_ff @(posedge clk) begin
		if (rst || !mirror_park_cmd)
			park_run <= 0;
		else
			park_run <= park_run + 1;
	end
	tri_hiz_a: assert property (!sys_reset_low[*4] |-> &tri_oe_low)
		else $error("pins not high-z in reset");
	bidir_in_a: assert property (!sys_reset_low[*4] |->
		bidir_oe_low && outputs_inactive) else $error("pins not quiet");
	pins_live_a: assert property ((sys_reset_low && !rst)[*6] |->
		!bidir_oe_low) else $error("pins not active");
	irq_drive_a: assert property ($fell(host_irq_oe_low) |-> host_irq_out)
		else $error("irq not driven high");
	irq_done_a: assert property (status.init_done |->
		!host_irq_out && !host_irq_oe_low) else $error("irq not low");
	cfg_order_a: assert property ($rose(cfg_load_start) |->
		$past(pll_locked, 2)) else $error("load before lock");
	park_bound_a: assert property (park_run <= PARK_SEQ_CYC)
		else $error("park too long");
	irq_hold_a: assert property ($fell(host_irq_out) |=>
		!host_irq_out[*8]) else $error("irq bounced");
	cover property ($fell(host_irq_out));
	cover property ($rose(mirror_park_cmd));
	cover property ($rose(status.parked));
endmodule : dcip_chk
bind dcip_init_park_seq dcip_chk dcip_chk_inst (.clk, .rst, .sys_reset_low,
	.pll_locked, .cfg_load_start, .mirror_park_cmd, .host_irq_out,
	.host_irq_oe_low, .tri_oe_low, .bidir_oe_low, .outputs_inactive, .status);
`default_nettype wire

// >>> tb/dcip_partner.sv
`timescale 1ns/10ps
`default_nettype none
module dcip_partner (
	// core side
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic start,
	input  wire logic park,
	input  wire logic slow,
	output logic      locked,
	output logic      done,
	output logic      ack
);
	int n;
	always_ff @(posedge clk) begin
		if (rst) begin
			n <= 0;
			locked <= 1'h0;
			done <= 1'h0;
			ack <= 1'h0;
		end else begin
			n <= n + 1;
			locked <= n > (slow ? 200 : 20);
			done <= start && ($urandom % (slow ? 16 : 2) == 0);
			// slow partner never acks, so the timer must end the park
			ack <= park && !slow && ($urandom % 4 == 0);
		end
	end
endmodule : dcip_partner
`default_nettype wire

// >>> tb/test_display_ctrl_init_park_seq.sv
`timescale 1ns/10ps
`default_nettype none
module test_display_ctrl_init_park_seq;
	import dcip_pkg::*;
	logic       clk, rst, srl, pk, pon, slow, lock, done, ack;
	logic       start, pcmd, irq, irq_oe, bi_oe, inact;
	dcip_tri_t  tri_oe;
	dcip_stat_t stat;
	int         err_total, tests_run, k;
	always #2 clk = ~clk;
	dcip_init_park_seq dcip_init_park_seq_inst (.clk, .rst,
		.sys_reset_low(srl), .mirror_park_request_low(pk),
		.projector_power_request(pon), .pll_locked(lock),
		.cfg_load_done(done), .cfg_load_start(start),
		.mirror_park_cmd(pcmd), .mirror_park_ack(ack), .host_irq_out(irq),
		.host_irq_oe_low(irq_oe), .tri_oe_low(tri_oe), .bidir_oe_low(bi_oe),
		.outputs_inactive(inact), .status(stat));
	dcip_partner dcip_partner_inst (.clk, .rst(rst | ~srl), .start,
		.park(pcmd), .slow, .locked(lock), .done, .ack);
	task automatic chk(input logic [4:0] got, input logic [4:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wrap_up;
		if (err_total == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : wrap_up
	function automatic logic cnd(input int c);
		case (c)
			0: return irq === 1'h0;
			1: return pcmd === 1'h1;
			default: return stat.parked === 1'h1;
		endcase
	endfunction : cnd
	task automatic w(input int c);
		int n;
		n = 0;
		while (!cnd(c) && n < 9000) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 9000) begin
			err_total++;
			wrap_up();
		end
	endtask : w
	initial begin
		clk = 0; rst = 1; srl = 0; pk = 1; pon = 0; slow = 0;
		err_total = 0; tests_run = 0;
		void'($urandom(53));
		for (k = 0; k < 2; k++) begin
			// park high while reset is held
			@(posedge clk) begin
				rst <= !k[0]; srl <= 0; pk <= 1; pon <= 0; slow <= k[0];
			end
			repeat (4) @(posedge clk);
			#1 chk(tri_oe, 5'h1f);
			chk({2'h0, bi_oe, inact, irq_oe}, 5'h07);
			@(posedge clk) begin
				rst <= 0; srl <= 1; pon <= 1;
			end
			repeat (6) @(posedge clk);
			#1 chk({2'h0, bi_oe, irq_oe, irq}, 5'h01);
			chk(stat, 5'h10);
			// host waits for the interrupt low
			w(0);
			chk({4'h0, stat.init_done}, 5'h01);
			@(posedge clk) pk <= 0;
			repeat (1 + $urandom % 30) @(posedge clk);
			pk <= 1;
			repeat (12) @(posedge clk);
			#1 chk({4'h0, pcmd}, 5'h00);
			chk(stat, 5'h08);
			if (k == 0)
				@(posedge clk) pk <= 0;
			else
				@(posedge clk) pon <= 0;
			w(1);
			w(2);
			chk({3'h0, irq, pcmd}, 5'h00);
			chk(stat, k[0] ? 5'h03 : 5'h02);
			// clock and reset held 32 us after park
			repeat (PARK_WARN_CYC) @(posedge clk);
		end
		wrap_up();
	end
endmodule : test_display_ctrl_init_park_seq
`default_nettype wire
